// ### include/gc_svc_pkg.sv
package gc_svc_pkg;
   localparam logic [10:0] GC_CMD_CELL_OFS = 11'h03C;
   localparam logic [7:0] GC_CMD_RESET = 8'h00;
   localparam int BIT_WIPE = 1;
   localparam int BIT_IN_RELEASE = 2;
   localparam int BIT_IN_HOLD = 3;
   localparam int BIT_OUT_RELEASE = 4;
   localparam int BIT_OUT_HOLD = 5;
   localparam int PTR_W = 2;
   localparam logic [1:0] PTR_NIL = 2'h0;
   localparam logic [1:0] PTR_B1 = 2'h1;
   localparam logic [1:0] PTR_B2 = 2'h2;
   localparam logic [1:0] PTR_B3 = 2'h3;

   typedef enum logic [1:0] {
      REQ_NONE = 2'b00,
      REQ_READ_IN = 2'b01,
      REQ_READ_OUT = 2'b10,
      REQ_READ_CFG = 2'b11
   } req_e;

   typedef struct packed {
      logic [1:0] f;
      logic [1:0] u;
      logic [1:0] n;
      logic [1:0] d;
   } slots_s;

   typedef struct packed {
      logic [7:0] gc_cmd;
      logic [7:0] gc_last;
      logic gc_seen;
      logic irq;
      logic in_hold;
      logic out_hold;
      slots_s din;
      slots_s dout;
      logic cfg_sel;
      logic wipe;
      logic [1:0] wipe_ptr;
      logic [1:0] reply_ptr;
      logic reply_cfg;
      logic reply_vld;
      logic [7:0] rd_data;
   } state_s;
endpackage : gc_svc_pkg

// ### hdl/gc_services.sv
// Summary of operation
// - Valid group control byte one stored in cell 3CH; group select used internally.
// - Cell bits: 1 wipe, 2 input release, 3 input hold, 4 output release, 5 output hold.
// - Output wipe clears bus-side output buffer then moves it to next-available.
// - Input hold moves next-available input to bus-side and freezes it there.
// - Input release cancels hold, normal input rotation resumes before each send.
// - Output hold moves latest bus-side output to next-available; later data stays.
// - Output release cancels hold; output buffers swap on every data exchange.
// - New group command interrupt only when command byte differs from previous.
// - Command cell presets to zero at init and is always readable.
// - Hold functions act only when their mode enable bits are set.
// - Read inputs swaps next-available to bus-side if new, unless held; replies.
// - Read outputs replies from the host-owned output buffer.
// - Repeated read outputs sends the host's newly claimed buffer.
// - Read config replies from readback buffer; swap request exchanges config buffers.
// - Under output hold, data exchange fills bus-side without exchange.
`timescale 1ns/1ps
module gc_services
   import gc_svc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_gc_valid,
   input wire logic [7:0] i_gc_cmd,
   input wire logic [7:0] i_gc_group,
   input wire logic [7:0] i_group_addr,
   input wire logic i_dx_done,
   input wire logic [1:0] i_req,
   input wire logic i_en_in_hold,
   input wire logic i_en_out_hold,
   input wire logic i_host_din_new,
   input wire logic [1:0] i_host_din_ptr,
   input wire logic i_host_dout_next,
   input wire logic i_cfg_swap_req,
   input wire logic [10:0] i_rd_addr,
   output logic [7:0] o_rd_data,
   output logic o_new_group_command_irq,
   output logic o_in_hold,
   output logic o_out_hold,
   output logic [7:0] o_din_sm,
   output logic [7:0] o_dout_sm,
   output logic o_wipe,
   output logic [1:0] o_wipe_ptr,
   output logic o_reply_vld,
   output logic [1:0] o_reply_ptr,
   output logic o_reply_cfg,
   output logic o_cfg_sel
);
   state_s s_q;
   state_s s_d;
   logic grp_hit;
   req_e req;

   assign req = req_e'(i_req);
   // Group select evaluated internally
   assign grp_hit = (i_gc_group == 8'h00) || ((i_gc_group & i_group_addr) != 8'h00);

   always_comb begin
      s_d = s_q;
      s_d.irq = 1'b0;
      s_d.wipe = 1'b0;
      s_d.reply_vld = 1'b0;
      // Host-side buffer handovers
      if (i_host_din_new) begin
         s_d.din.n = s_q.din.u;
         s_d.din.u = (s_q.din.n != PTR_NIL) ? s_q.din.n : s_q.din.f;
         if (s_q.din.n == PTR_NIL) begin
            s_d.din.f = PTR_NIL;
         end
      end
      if (i_host_dout_next && s_q.dout.n != PTR_NIL) begin
         s_d.dout.f = s_q.dout.u;
         s_d.dout.u = s_q.dout.n;
         s_d.dout.n = PTR_NIL;
      end
      // Data exchange output rotation
      if (i_dx_done && !s_q.out_hold) begin
         if (s_d.dout.n != PTR_NIL) begin
            s_d.dout.f = s_d.dout.n;
         end
         s_d.dout.n = s_d.dout.d;
         s_d.dout.d = (s_d.dout.f != PTR_NIL) ? s_d.dout.f : s_d.dout.n;
         s_d.dout.f = PTR_NIL;
      end
      if (i_gc_valid && grp_hit) begin
         s_d.gc_cmd = i_gc_cmd;
         s_d.gc_seen = 1'b1;
         s_d.gc_last = i_gc_cmd;
         s_d.irq = s_q.gc_seen ? (i_gc_cmd != s_q.gc_last) : (i_gc_cmd != GC_CMD_RESET);
         if (i_gc_cmd[BIT_WIPE]) begin
            s_d.wipe = 1'b1;
            s_d.wipe_ptr = s_d.dout.d;
         end
         if ((i_gc_cmd[BIT_WIPE] || (i_en_out_hold &&
              (i_gc_cmd[BIT_OUT_HOLD] || i_gc_cmd[BIT_OUT_RELEASE])))) begin
            if (s_d.dout.n != PTR_NIL) begin
               s_d.dout.f = s_d.dout.n;
            end
            s_d.dout.n = s_d.dout.d;
            s_d.dout.d = s_d.dout.f;
            s_d.dout.f = PTR_NIL;
         end
         if (i_en_out_hold && i_gc_cmd[BIT_OUT_HOLD]) begin
            s_d.out_hold = 1'b1;
         end else if (i_gc_cmd[BIT_OUT_RELEASE]) begin
            s_d.out_hold = 1'b0;
         end
         if (i_en_in_hold && i_gc_cmd[BIT_IN_HOLD]) begin
            s_d.in_hold = 1'b1;
            if (s_d.din.n != PTR_NIL) begin
               s_d.din.f = s_d.din.d;
               s_d.din.d = s_d.din.n;
               s_d.din.n = PTR_NIL;
            end
         end else if (i_gc_cmd[BIT_IN_RELEASE]) begin
            s_d.in_hold = 1'b0;
         end
      end
      if (i_cfg_swap_req) begin
         s_d.cfg_sel = ~s_q.cfg_sel;
      end
      unique case (req)
         REQ_NONE: begin
         end
         REQ_READ_IN: begin
            if (!s_d.in_hold && s_d.din.n != PTR_NIL) begin
               s_d.din.f = s_d.din.d;
               s_d.din.d = s_d.din.n;
               s_d.din.n = PTR_NIL;
            end
            s_d.reply_ptr = s_d.din.d;
            s_d.reply_cfg = 1'b0;
            s_d.reply_vld = 1'b1;
         end
         REQ_READ_OUT: begin
            s_d.reply_ptr = s_d.dout.u;
            s_d.reply_cfg = 1'b0;
            s_d.reply_vld = 1'b1;
         end
         REQ_READ_CFG: begin
            s_d.reply_ptr = PTR_NIL;
            s_d.reply_cfg = 1'b1;
            s_d.reply_vld = 1'b1;
         end
      endcase
      if (i_host_din_new) begin
         s_d.din.u = i_host_din_ptr;
      end
      s_d.rd_data = (i_rd_addr == GC_CMD_CELL_OFS) ? s_d.gc_cmd : 8'h00;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         s_q <= '0;
         s_q.gc_cmd <= GC_CMD_RESET;
         s_q.din <= '{f: PTR_B3, u: PTR_B1, n: PTR_NIL, d: PTR_B2};
         s_q.dout <= '{f: PTR_B3, u: PTR_B1, n: PTR_NIL, d: PTR_B2};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rd_data = s_q.rd_data;
   assign o_new_group_command_irq = s_q.irq;
   assign o_in_hold = s_q.in_hold;
   assign o_out_hold = s_q.out_hold;
   assign o_din_sm = s_q.din;
   assign o_dout_sm = s_q.dout;
   assign o_wipe = s_q.wipe;
   assign o_wipe_ptr = s_q.wipe_ptr;
   assign o_reply_vld = s_q.reply_vld;
   assign o_reply_ptr = s_q.reply_ptr;
   assign o_reply_cfg = s_q.reply_cfg;
   assign o_cfg_sel = s_q.cfg_sel;

   a_irq_on_change: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_gc_valid && grp_hit && s_q.gc_seen && i_gc_cmd == s_q.gc_last) |=> !o_new_group_command_irq)
      else $error("irq raised for unchanged command");
   a_cell_store: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_gc_valid && grp_hit) |=> (s_q.gc_cmd == $past(i_gc_cmd)))
      else $error("command byte not stored");
   a_hold_gated: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (!i_en_in_hold && !s_q.in_hold) |=> !s_q.in_hold)
      else $error("input hold without enable");
   a_in_frozen: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (s_q.in_hold && req == REQ_READ_IN && !(i_gc_valid && grp_hit)) |=> (s_q.din.d == $past(s_q.din.d)))
      else $error("held input buffer changed");
   a_out_frozen: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (s_q.out_hold && i_dx_done && !i_gc_valid) |=> (s_q.dout.d == $past(s_q.dout.d)))
      else $error("held output buffer exchanged");
   a_wipe_ptr: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_gc_valid && grp_hit && i_gc_cmd[BIT_WIPE] && !i_dx_done && !i_host_dout_next)
      |=> (o_wipe && s_q.dout.n == o_wipe_ptr))
      else $error("wiped buffer not moved");
   a_rdout_src: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (req == REQ_READ_OUT) |=> (o_reply_vld && o_reply_ptr == s_q.dout.u))
      else $error("read outputs not from host buffer");
   a_cfg_swap: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_cfg_swap_req |=> (o_cfg_sel != $past(o_cfg_sel)))
      else $error("config buffers not exchanged");
   a_out_rotate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (!s_q.out_hold && i_dx_done && !i_gc_valid) |=> (s_q.dout.n == $past(s_q.dout.d)))
      else $error("output buffers not exchanged on data exchange");
   a_in_fetch: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (!s_q.in_hold && req == REQ_READ_IN && !i_gc_valid && !i_host_din_new && s_q.din.n != PTR_NIL) |=> (s_q.din.d == $past(s_q.din.n)))
      else $error("new input buffer not fetched");
   a_rd_cell: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_rd_addr == GC_CMD_CELL_OFS) |=> (o_rd_data == s_q.gc_cmd))
      else $error("command cell read wrong");
   a_irq_on_new: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_gc_valid && grp_hit && s_q.gc_seen && i_gc_cmd != s_q.gc_last) |=> o_new_group_command_irq)
      else $error("irq missing for changed command");
   a_grp_ignored: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_gc_valid && !grp_hit) |=> (s_q.gc_cmd == $past(s_q.gc_cmd) && !o_new_group_command_irq))
      else $error("telegram for other group taken");
   a_out_release: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_gc_valid && grp_hit && i_gc_cmd[BIT_OUT_RELEASE] && !i_gc_cmd[BIT_OUT_HOLD]) |=> !o_out_hold)
      else $error("output hold not cancelled");
   a_cfg_reply: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (req == REQ_READ_CFG) |=> (o_reply_vld && o_reply_cfg))
      else $error("read config not from readback buffer");
endmodule : gc_services

// ### verification/fb_master.sv
`timescale 1ns/1ps
module fb_master
   import gc_svc_pkg::*;
(
   input wire logic i_mclk,
   output logic o_gc_valid,
   output logic [7:0] o_gc_cmd,
   output logic [7:0] o_gc_group,
   output logic o_dx_done,
   output req_e o_req
);
   initial begin
      o_gc_valid = 1'b0;
      o_gc_cmd = 8'h00;
      o_gc_group = 8'h00;
      o_dx_done = 1'b0;
      o_req = REQ_NONE;
   end
   // Group control telegram, one cycle; bytes scrambled once released
   task send_gc(input logic [7:0] cmd, input logic [7:0] grp);
      @(negedge i_mclk);
      o_gc_valid = 1'b1;
      o_gc_cmd = cmd;
      o_gc_group = grp;
      @(negedge i_mclk);
      o_gc_valid = 1'b0;
      o_gc_cmd = ~cmd;
      o_gc_group = ~grp;
   endtask : send_gc
   task send_dx;
      @(negedge i_mclk);
      o_dx_done = 1'b1;
      @(negedge i_mclk);
      o_dx_done = 1'b0;
   endtask : send_dx
   task send_req(input req_e r);
      @(negedge i_mclk);
      o_req = r;
      @(negedge i_mclk);
      o_req = REQ_NONE;
   endtask : send_req
endmodule : fb_master

// ### verification/gc_services_tb_top.sv
`timescale 1ns/1ps
module gc_services_tb_top import gc_svc_pkg::*; ;
   logic i_mclk, i_sys_rst, i_gc_valid, i_dx_done, i_en_in_hold, i_en_out_hold;
   logic i_host_din_new, i_host_dout_next, i_cfg_swap_req;
   logic [7:0] i_gc_cmd, i_gc_group, i_group_addr, o_rd_data, o_din_sm, o_dout_sm;
   logic [1:0] i_host_din_ptr, o_wipe_ptr, o_reply_ptr;
   logic [10:0] i_rd_addr;
   logic o_irq, o_in_hold, o_out_hold, o_wipe, o_reply_vld, o_reply_cfg, o_cfg_sel;
   req_e i_req;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [7:0] dout_buf [0:3];
   fb_master mst (.i_mclk(i_mclk), .o_gc_valid(i_gc_valid), .o_gc_cmd(i_gc_cmd),
      .o_gc_group(i_gc_group), .o_dx_done(i_dx_done), .o_req(i_req));
   gc_services uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_gc_valid(i_gc_valid),
      .i_gc_cmd(i_gc_cmd), .i_gc_group(i_gc_group), .i_group_addr(i_group_addr),
      .i_dx_done(i_dx_done), .i_req(i_req), .i_en_in_hold(i_en_in_hold),
      .i_en_out_hold(i_en_out_hold), .i_host_din_new(i_host_din_new),
      .i_host_din_ptr(i_host_din_ptr), .i_host_dout_next(i_host_dout_next),
      .i_cfg_swap_req(i_cfg_swap_req), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
      .o_new_group_command_irq(o_irq), .o_in_hold(o_in_hold), .o_out_hold(o_out_hold),
      .o_din_sm(o_din_sm), .o_dout_sm(o_dout_sm), .o_wipe(o_wipe), .o_wipe_ptr(o_wipe_ptr),
      .o_reply_vld(o_reply_vld), .o_reply_ptr(o_reply_ptr), .o_reply_cfg(o_reply_cfg),
      .o_cfg_sel(o_cfg_sel));
   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task end_sim;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         end_sim;
      end
   end
   // Host strobes: k[0] input handover, k[1] output take, k[2] config swap
   task hpulse(input logic [2:0] k, input logic [1:0] p);
      @(negedge i_mclk);
      {i_cfg_swap_req, i_host_dout_next, i_host_din_new} = k;
      i_host_din_ptr = p;
      @(negedge i_mclk);
      {i_cfg_swap_req, i_host_dout_next, i_host_din_new} = 3'h0;
      i_host_din_ptr = ~p;
   endtask : hpulse
   task rd(input logic [10:0] a, input logic [7:0] exp);
      @(negedge i_mclk);
      i_rd_addr = a;
      @(negedge i_mclk);
      chk(o_rd_data, exp);
   endtask : rd
   task t_reset;
      chk(o_din_sm, 8'hD2);
      chk(o_dout_sm, 8'hD2);
      chk({o_irq, o_in_hold, o_out_hold}, 8'h00);
      rd(GC_CMD_CELL_OFS, GC_CMD_RESET);
      rd(11'h000, 8'h00);
   endtask : t_reset
   task t_in_hold;
      hpulse(3'h1, 2'h3);
      mst.send_gc(8'h08, 8'h02);
      chk({o_irq, o_in_hold}, 8'h00);
      mst.send_gc(8'h08, 8'h00);
      chk({o_irq, o_in_hold}, 8'h03);
      chk(8'(o_din_sm[1:0]), 8'h01);
      rd(GC_CMD_CELL_OFS, 8'h08);
      mst.send_req(REQ_READ_IN);
      chk({o_reply_vld, o_reply_ptr}, 8'h05);
      mst.send_gc(8'h04, 8'h00);
      chk({o_irq, o_in_hold}, 8'h02);
      mst.send_gc(8'h04, 8'h00);
      chk(8'(o_irq), 8'h00);
      hpulse(3'h1, 2'h2);
      mst.send_req(REQ_READ_IN);
      chk({o_reply_vld, o_reply_ptr}, 8'h07);
      i_en_in_hold = 1'b0;
      mst.send_gc(8'h08, 8'h00);
      chk({o_irq, o_in_hold}, 8'h02);
   endtask : t_in_hold
   task t_out;
      mst.send_gc(8'h02, 8'h01);
      chk({o_wipe, o_wipe_ptr}, 8'h06);
      chk(8'(o_dout_sm[3:2]), 8'h02);
      mst.send_req(REQ_READ_OUT);
      chk({o_reply_vld, o_reply_ptr}, 8'h05);
      chk(dout_buf[o_reply_ptr], 8'h00);
      hpulse(3'h2, 2'h0);
      mst.send_req(REQ_READ_OUT);
      chk({o_reply_vld, o_reply_ptr}, 8'h06);
      mst.send_gc(8'h20, 8'h00);
      chk(8'(o_out_hold), 8'h01);
      mst.send_gc(8'h10, 8'h00);
      chk(8'(o_out_hold), 8'h00);
      mst.send_gc(8'hC1, 8'h00);
      chk({o_irq, o_wipe, o_in_hold, o_out_hold}, 8'h08);
      rd(GC_CMD_CELL_OFS, 8'hC1);
   endtask : t_out
   task t_dx;
      mst.send_dx;
      chk(o_dout_sm, 8'h2D);
      mst.send_gc(8'h20, 8'h00);
      mst.send_dx;
      chk(o_dout_sm, 8'h27);
      mst.send_gc(8'h10, 8'h00);
      chk(o_dout_sm, 8'h2D);
   endtask : t_dx
   task t_cfg;
      mst.send_req(REQ_READ_CFG);
      chk({o_reply_vld, o_reply_cfg, o_cfg_sel}, 8'h06);
      hpulse(3'h4, 2'h0);
      chk(8'(o_cfg_sel), 8'h01);
      mst.send_req(REQ_READ_CFG);
      chk({o_reply_vld, o_reply_cfg, o_cfg_sel}, 8'h07);
      // Host leaves online after the change, block re-initialises
      @(negedge i_mclk);
      i_sys_rst = 1'b1;
      @(negedge i_mclk);
      i_sys_rst = 1'b0;
      t_reset;
   endtask : t_cfg
   initial begin
      i_sys_rst = 1'b1;
      i_group_addr = 8'h01;
      i_en_in_hold = 1'b1;
      i_en_out_hold = 1'b1;
      {i_cfg_swap_req, i_host_dout_next, i_host_din_new} = 3'h0;
      i_host_din_ptr = 2'h0;
      i_rd_addr = GC_CMD_CELL_OFS;
      dout_buf = '{default: 8'h00};
      repeat (4) @(negedge i_mclk);
      i_sys_rst = 1'b0;
      t_reset;
      t_in_hold;
      t_out;
      t_dx;
      t_cfg;
      end_sim;
   end
endmodule : gc_services_tb_top
